// >>> src/gfc_pkg.sv
// shared constants and types of the gated frequency counter
package gfc_pkg;
    // clock and gate timing
    localparam int CLK_HZ = 200_000_000;
    localparam int GATE_MIN_TIME_US = 10_000;
    localparam int GATE_MIN_CYCLES = GATE_MIN_TIME_US * (CLK_HZ / 1_000_000);
    localparam int GATE_BASE_MAX = 4_000_000;
    localparam int MAX_INPUT_HZ = 150_000_000;

    // display layout
    localparam int DIGITS = 6;
    localparam int BCD_W = 4 * DIGITS;
    localparam logic [3:0] BCD_NINE = 4'h9;

    // register offsets
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_RESULT = 8'h08;
    localparam logic [7:0] ADDR_INT_STAT = 8'h0c;
    localparam logic [7:0] ADDR_INT_MASK = 8'h10;

    // field positions
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_GATE_LSB = 1;
    localparam int STAT_EN_BIT = 0;
    localparam int STAT_GATE_LSB = 1;
    localparam int STAT_FLASH_BIT = 3;
    localparam int STAT_OVER_BIT = 4;
    localparam int RESULT_OVER_BIT = 24;
    localparam int INT_DONE_BIT = 0;
    localparam int INT_OVER_BIT = 1;
    localparam int INT_W = 2;

    // unit lights
    localparam logic [1:0] UNIT_HZ = 2'h1;
    localparam logic [1:0] UNIT_KHZ = 2'h2;

    // reset values
    localparam logic [INT_W-1:0] INT_MASK_RESET = 2'h0;

    // gate time choices, in cycling order
    typedef enum logic [1:0] {
        GATE_10MS,
        GATE_100MS,
        GATE_1S,
        GATE_10S
    } gfc_gate_t;

    // window state
    typedef enum logic {
        ST_IDLE,
        ST_COUNT
    } gfc_state_t;
endpackage

// >>> src/gfc_cnt_if.sv
// carrier between the window control and the decimal edge counter
`timescale 1ns/10ps
interface gfc_cnt_if;
    import gfc_pkg::*;
    logic inc;
    logic clr;
    logic [BCD_W-1:0] digits;
    logic over;
    modport owner (output inc, output clr, input digits, input over);
    modport counter (input inc, input clr, output digits, output over);
endinterface

// >>> src/gfc_bcd_counter.sv
// six-digit decimal edge counter with sticky carry-out flag
`timescale 1ns/10ps
module gfc_bcd_counter
    import gfc_pkg::*;
(
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // control and result
    gfc_cnt_if.counter cnt
);
    logic [DIGITS:0] carry;
    logic over;
    logic next_over;

    // counting in decimal avoids a binary to decimal conversion per window
    assign carry[0] = cnt.inc;

    for (genvar i = 0; i < DIGITS; i++) begin : g_dig
        logic [3:0] d;
        logic [3:0] next_d;
        assign carry[i+1] = carry[i] && (d == BCD_NINE);
        assign cnt.digits[4*i +: 4] = d;
        // an edge in the clearing cycle opens the next window at one
        always_comb begin
            next_d = d;
            if (cnt.clr) begin
                next_d = (i == 0 && cnt.inc) ? 4'h1 : 4'h0;
            end else if (carry[i]) begin
                next_d = (d == BCD_NINE) ? 4'h0 : d + 4'h1;
            end
        end
        always_ff @(posedge clk_in or posedge rst_in) begin
            if (rst_in) begin
                d <= 4'h0;
            end else begin
                d <= next_d;
            end
        end
        chk_digit_decimal: assert property (
            @(posedge clk_in) disable iff (rst_in) d <= BCD_NINE)
            else $error("digit left the decimal range");
    end

    // carry out of the top digit means more than six digits
    always_comb begin
        next_over = cnt.clr ? 1'b0 : (over || carry[DIGITS]);
    end
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            over <= 1'b0;
        end else begin
            over <= next_over;
        end
    end
    assign cnt.over = over;

    chk_clear_restart: assert property (
        @(posedge clk_in) disable iff (rst_in)
        cnt.clr && !cnt.inc |=> cnt.digits == '0 && !cnt.over)
        else $error("counter not restarted by clear");
    chk_carry_over: assert property (
        @(posedge clk_in) disable iff (rst_in)
        carry[DIGITS] && !cnt.clr |=> cnt.over && cnt.digits == '0)
        else $error("top carry did not raise overflow");
endmodule

// >>> src/gfc_top.sv
// gated frequency counter: keys, gate windows, display, registers
`timescale 1ns/10ps
module gfc_top
    import gfc_pkg::*;
#(
    parameter int unsigned GATE_BASE_CYCLES = GATE_MIN_CYCLES
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // test signal and front-panel keys
    input wire logic sig_in,
    input wire logic key_gate_in,
    input wire logic key_shift_in,
    // register port
    input wire logic [7:0] addr_in,
    input wire logic [31:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [31:0] rdata_out,
    // display and lights
    output logic [BCD_W-1:0] digits_out,
    output logic [2:0] dp_out,
    output logic [1:0] unit_out,
    output logic over_out,
    output logic external_source_indicator_out,
    output logic [3:0] gate_led_out,
    output logic gate_flash_out,
    // interrupt
    output logic irq_out
);
    if (GATE_BASE_CYCLES < 1 || GATE_BASE_CYCLES > GATE_BASE_MAX) begin : g_chk
        $error("gate base cycles out of range");
    end

    gfc_cnt_if cnt ();

    gfc_bcd_counter u_cnt (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .cnt(cnt)
    );

    // window length in cycles for a gate choice
    function automatic logic [31:0] gate_len(gfc_gate_t g);
        logic [31:0] b;
        b = 32'(GATE_BASE_CYCLES);
        case (g)
            GATE_10MS: gate_len = b;
            GATE_100MS: gate_len = 32'(b * 32'd10);
            GATE_1S: gate_len = 32'(b * 32'd100);
            default: gate_len = 32'(b * 32'd1000);
        endcase
    endfunction

    // decimal point places for a gate: the count unit is one over the gate
    function automatic logic [2:0] gate_dp(gfc_gate_t g);
        case (g)
            GATE_10MS: gate_dp = 3'h1;
            GATE_100MS: gate_dp = 3'h2;
            GATE_1S: gate_dp = 3'h3;
            default: gate_dp = 3'h1;
        endcase
    endfunction

    logic [2:0] sig_sync, next_sig_sync;
    logic [2:0] gate_sync, next_gate_sync;
    logic [1:0] shift_sync, next_shift_sync;
    logic edge_seen, press_gate, shift_held;

    // pins are asynchronous: two flops, then a third for edge detection
    always_comb begin
        next_sig_sync = {sig_sync[1:0], sig_in};
        next_gate_sync = {gate_sync[1:0], key_gate_in};
        next_shift_sync = {shift_sync[0], key_shift_in};
    end
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            sig_sync <= 3'h0;
            gate_sync <= 3'h0;
            shift_sync <= 2'h0;
        end else begin
            sig_sync <= next_sig_sync;
            gate_sync <= next_gate_sync;
            shift_sync <= next_shift_sync;
        end
    end
    // sampling at 200 MHz resolves edges only while the input stays
    // below half the clock
    assign edge_seen = sig_sync[1] && !sig_sync[2];
    assign press_gate = gate_sync[1] && !gate_sync[2];
    assign shift_held = shift_sync[1];

    gfc_state_t state, next_state;
    gfc_gate_t gate, next_gate;
    logic en, next_en;
    logic [31:0] tmr, next_tmr;
    logic [BCD_W-1:0] next_digits;
    logic [2:0] next_dp;
    logic [1:0] next_unit;
    logic next_over, next_flash;
    logic [3:0] next_leds;
    logic [INT_W-1:0] int_stat, next_int_stat, int_mask, next_int_mask;
    logic [INT_W-1:0] int_set;
    logic [31:0] next_rdata;
    logic next_irq, restart, win_end;

    assign win_end = (state == ST_COUNT) && (tmr == 32'h0);

    // key, register and window control
    always_comb begin
        next_en = en;
        next_gate = gate;
        restart = 1'b0;
        if (press_gate && shift_held) begin
            next_en = !en;
            restart = 1'b1;
        end else if (press_gate && en) begin
            next_gate = gfc_gate_t'(gate + 2'h1);
            restart = 1'b1;
        end else if (wr_in && addr_in == ADDR_CTRL) begin
            next_en = wdata_in[CTRL_EN_BIT];
            next_gate = gfc_gate_t'(wdata_in[CTRL_GATE_LSB +: 2]);
            restart = 1'b1;
        end
        next_state = state;
        next_tmr = tmr;
        cnt.clr = 1'b0;
        cnt.inc = edge_seen && en;
        if (!next_en) begin
            next_state = ST_IDLE;
            cnt.clr = 1'b1;
        end else if (restart || state == ST_IDLE || win_end) begin
            // a new window: restart count and timer together
            next_state = ST_COUNT;
            next_tmr = gate_len(next_gate) - 32'h1;
            cnt.clr = 1'b1;
            // the load cycle is the first cycle of the new window, so an
            // edge seen here belongs to it and every window spans L cycles
            cnt.inc = edge_seen;
        end else begin
            next_tmr = tmr - 32'h1;
        end
    end

    // display capture; gate LEDs follow the gate choice right away
    always_comb begin
        next_digits = digits_out;
        next_dp = dp_out;
        next_unit = unit_out;
        next_over = over_out;
        next_flash = gate_flash_out;
        int_set = '0;
        if (win_end && !restart) begin
            next_digits = cnt.digits;
            next_over = cnt.over;
            next_dp = gate_dp(gate);
            next_unit = (gate == GATE_10S) ? UNIT_HZ : UNIT_KHZ;
            next_flash = !gate_flash_out;
            int_set[INT_DONE_BIT] = 1'b1;
            int_set[INT_OVER_BIT] = cnt.over;
        end
        if (!next_en) begin
            next_flash = 1'b0;
        end
        next_leds = next_en ? (4'h1 << next_gate) : 4'h0;
    end

    // register reads; interrupt status clears on read, a new event wins
    always_comb begin
        next_rdata = 32'h0;
        next_int_mask = int_mask;
        next_int_stat = int_stat | int_set;
        if (wr_in && addr_in == ADDR_INT_MASK) begin
            next_int_mask = wdata_in[INT_W-1:0];
        end
        if (rd_in) begin
            if (addr_in == ADDR_CTRL) begin
                next_rdata[CTRL_EN_BIT] = en;
                next_rdata[CTRL_GATE_LSB +: 2] = gate;
            end else if (addr_in == ADDR_STATUS) begin
                next_rdata[STAT_EN_BIT] = en;
                next_rdata[STAT_GATE_LSB +: 2] = gate;
                next_rdata[STAT_FLASH_BIT] = gate_flash_out;
                next_rdata[STAT_OVER_BIT] = over_out;
            end else if (addr_in == ADDR_RESULT) begin
                next_rdata[BCD_W-1:0] = digits_out;
                next_rdata[RESULT_OVER_BIT] = over_out;
            end else if (addr_in == ADDR_INT_STAT) begin
                next_rdata[INT_W-1:0] = int_stat;
                next_int_stat = int_set;
            end else if (addr_in == ADDR_INT_MASK) begin
                next_rdata[INT_W-1:0] = int_mask;
            end
        end
        next_irq = |(next_int_stat & next_int_mask);
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            state <= ST_IDLE;
            gate <= GATE_10MS;
            en <= 1'b0;
            tmr <= 32'h0;
            digits_out <= '0;
            dp_out <= 3'h0;
            unit_out <= 2'h0;
            over_out <= 1'b0;
            gate_flash_out <= 1'b0;
            gate_led_out <= 4'h0;
            external_source_indicator_out <= 1'b0;
            int_stat <= '0;
            int_mask <= INT_MASK_RESET;
            rdata_out <= 32'h0;
            irq_out <= 1'b0;
        end else begin
            state <= next_state;
            gate <= next_gate;
            en <= next_en;
            tmr <= next_tmr;
            digits_out <= next_digits;
            dp_out <= next_dp;
            unit_out <= next_unit;
            over_out <= next_over;
            gate_flash_out <= next_flash;
            gate_led_out <= next_leds;
            external_source_indicator_out <= next_en;
            int_stat <= next_int_stat;
            int_mask <= next_int_mask;
            rdata_out <= next_rdata;
            irq_out <= next_irq;
        end
    end

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);

    sequence s_enable_press;
        press_gate && shift_held && !en;
    endsequence
    sequence s_lit_one_gate;
        external_source_indicator_out && $onehot(gate_led_out);
    endsequence

    chk_enable_lights: assert property (
        s_enable_press |=> s_lit_one_gate)
        else $error("enable did not light source and gate");
    chk_gate_cycle: assert property (
        press_gate && !shift_held && en |=>
        gate == gfc_gate_t'($past(gate) + 2'h1) &&
        gate_led_out == (4'h1 << gate))
        else $error("gate time did not step in order");
    chk_flash_pace: assert property (
        $changed(gate_flash_out) && en |-> $past(win_end))
        else $error("gate light changed outside a window end");
    chk_window_length: assert property (
        restart && next_en |=> tmr == gate_len(gate) - 32'h1)
        else $error("window not loaded with gate length");
    chk_display_latch: assert property (
        win_end && !restart |=> digits_out == $past(cnt.digits))
        else $error("display not taken from the window count");
    chk_over_light: assert property (
        win_end && !restart |=> over_out == $past(cnt.over))
        else $error("overflow light does not match count");
    chk_resolution_step: assert property (
        win_end && !restart |=> dp_out == gate_dp($past(gate)))
        else $error("decimal point does not follow gate");
    chk_irq_level: assert property (
        irq_out == |(int_stat & int_mask))
        else $error("interrupt level disagrees with status");
endmodule

// >>> verif/gfc_sig_src.sv
// test signal source that feeds the counter input
`timescale 1ns/10ps
module gfc_sig_src #(
    parameter real HALF_NS = 25.0
) (
    // control
    input wire logic en_in,
    // signal pin
    output logic sig_out
);
    // square wave while enabled, held low otherwise; the small offset keeps
    // edges away from the sampling clock edges
    initial begin
        sig_out = 1'b0;
        forever begin
            wait (en_in);
            #1.3;
            while (en_in) begin
                sig_out = 1'b1;
                #HALF_NS;
                sig_out = 1'b0;
                #HALF_NS;
            end
        end
    end
endmodule

// >>> verif/tb_gated_frequency_counter.sv
// self-checking bench of the gated frequency counter
`timescale 1ns/10ps
module tb_gated_frequency_counter;
    import gfc_pkg::*;
    logic clk_in = 1'b0, rst_in = 1'b1, sig, src_en = 1'b0;
    logic key_gate = 1'b0, key_shift = 1'b0, wr = 1'b0, rd = 1'b0, rd_q = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata_out;
    logic [BCD_W-1:0] digits_out;
    logic [2:0] dp_out;
    logic [1:0] unit_out;
    logic over_out, ext_out, gate_flash_out, irq_out, f;
    logic [3:0] gate_led_out;
    logic [63:0] exp_q[$];
    logic [63:0] e;
    int fails = 0, comparisons = 0, cycles = 0, cnt;

    always #2.5 clk_in = ~clk_in;

    gfc_top #(.GATE_BASE_CYCLES(20)) i_dut (.clk_in(clk_in), .rst_in(rst_in),
        .sig_in(sig), .key_gate_in(key_gate), .key_shift_in(key_shift),
        .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd),
        .rdata_out(rdata_out), .digits_out(digits_out), .dp_out(dp_out),
        .unit_out(unit_out), .over_out(over_out),
        .external_source_indicator_out(ext_out), .gate_led_out(gate_led_out),
        .gate_flash_out(gate_flash_out), .irq_out(irq_out));

    // 20 MHz source: ten clock cycles a period, so counts are exact
    gfc_sig_src #(.HALF_NS(25.0)) i_src (.en_in(src_en), .sig_out(sig));

    task automatic close_out();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic chk(string n, logic [31:0] ex, logic [31:0] got);
        comparisons++;
        if (got !== ex) begin
            $display("unexpected %s exp %h got %h", n, ex, got);
            fails++;
        end
    endtask

    // read data stand only in the cycle after the strobe
    always @(posedge clk_in) begin
        rd_q <= rd;
        if (rd_q) begin
            e = exp_q.pop_front();
            chk("rdata_out", e[63:32] & e[31:0], rdata_out & e[31:0]);
        end
    end

    // a hang is cut short here
    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 60000) begin
            fails++;
            close_out();
        end
    end

    task automatic wr_reg(logic [7:0] a, logic [31:0] d);
        @(posedge clk_in);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk_in);
        wr <= 1'b0;
    endtask

    // expected value and compare mask are noted before the strobe
    task automatic rd_reg(logic [7:0] a, logic [31:0] ex, logic [31:0] m);
        @(posedge clk_in);
        addr <= a;
        rd <= 1'b1;
        exp_q.push_back({ex, m});
        @(posedge clk_in);
        rd <= 1'b0;
    endtask

    // clean key press; long enough to pass the synchronisers
    task automatic press(logic s);
        @(posedge clk_in);
        key_shift <= s;
        key_gate <= 1'b1;
        repeat (8) @(posedge clk_in);
        key_gate <= 1'b0;
        key_shift <= 1'b0;
        repeat (6) @(posedge clk_in);
    endtask

    task automatic wait_irq();
        repeat (3) @(posedge clk_in);
        for (cnt = 0; cnt < 30000 && irq_out !== 1'b1; cnt++)
            @(posedge clk_in);
        chk("irq_out", 1, irq_out);
    endtask

    function automatic logic [23:0] to_bcd(int v);
        logic [23:0] r;
        for (int i = 0; i < 6; i++) begin
            r[4*i+:4] = 4'(v % 10);
            v = v / 10;
        end
        return r;
    endfunction

    initial begin
        logic [31:0] r;
        int n;
        logic [7:0] ua;
        void'($urandom(32'h061d));
        repeat (6) @(posedge clk_in);
        rst_in <= 1'b0;
        src_en <= 1'b1;
        // reset values, then an unmapped address
        for (int i = 0; i < 5; i++)
            rd_reg(8'(4 * i), 32'h0, 32'hffffffff);
        r = $urandom;
        // unmapped offset picked into a local, so the write uses it at once
        ua = 8'h14 + 8'($urandom % 200);
        wr_reg(ua, r);
        rd_reg(ua, 32'h0, 32'hffffffff);
        rd_reg(ADDR_CTRL, 32'h0, 32'hffffffff);
        wr_reg(ADDR_INT_MASK, r);
        rd_reg(ADDR_INT_MASK, r & 32'h3, 32'hffffffff);
        wr_reg(ADDR_INT_MASK, 32'h1);
        chk("ext", 0, ext_out);
        // enable with shift, then step through the gate times and wrap
        press(1'b1);
        for (int g = 0; g < 5; g++) begin
            if (g > 0)
                press(1'b0);
            chk("ext", 1, ext_out);
            chk("gate_led", 32'(4'h1 << (g % 4)), gate_led_out);
            rd_reg(ADDR_STATUS, 32'((g % 4) * 2 + 1), ~32'h8);
        end
        // one measurement for each gate time
        for (int g = 0; g < 4; g++) begin
            wr_reg(ADDR_CTRL, 32'(g * 2 + 1));
            rd_reg(ADDR_INT_STAT, 32'h0, 32'h2);
            wait_irq();
            n = 2 * (10 ** g);
            chk("digits", to_bcd(n), digits_out);
            chk("dp", (g == 3) ? 1 : g + 1, dp_out);
            chk("unit", (g == 3) ? UNIT_HZ : UNIT_KHZ, unit_out);
            chk("over", 0, over_out);
            f = gate_flash_out;
            rd_reg(ADDR_RESULT, to_bcd(n), 32'hffffffff);
            rd_reg(ADDR_INT_STAT, 32'h1, 32'hffffffff);
            if (g == 0) begin
                wait_irq();
                chk("flash", !f, gate_flash_out);
                wr_reg(ADDR_INT_MASK, 32'h0);
                repeat (25) @(posedge clk_in);
                chk("irq masked", 0, irq_out);
                wr_reg(ADDR_INT_MASK, 32'h1);
                repeat (3) @(posedge clk_in);
                chk("irq unmasked", 1, irq_out);
            end
            if (g == 3) begin
                repeat (3) @(posedge clk_in);
                chk("irq cleared", 0, irq_out);
            end
        end
        // disable: lights off, display holds, plain gate press ignored
        press(1'b1);
        chk("ext", 0, ext_out);
        chk("gate_led", 0, gate_led_out);
        chk("flash", 0, gate_flash_out);
        chk("digits", to_bcd(2000), digits_out);
        press(1'b0);
        rd_reg(ADDR_STATUS, 32'h6, 32'hffffffff);
        repeat (3) @(posedge clk_in);
        close_out();
    end
endmodule
